/* File: rtl/sdram_cmd_port.sv */
// Command and address port of a four-bank SDRAM device.
// Assumes a controller drives inputs synchronous to clk; sys_rst
// stands in for power-on initialization.
// Operation
// - Sample all inputs on rising clock only
// - Clock gate low halts core, enters low power
// - Decode commands only while select is low
// - Deselect ignores commands, bursts keep running
// - Three strobes pick the executed command
// - Activate takes twelve address bits as row
// - x4 column uses bits 0-9 and 11
// - x8 column uses bits 0-9
// - x16 column uses bits 0-8
// - Bit 10 high: autoprecharge bank after burst
// - Bit 10 low: bank stays open after burst
// - Precharge with bit 10 high closes all
// - Bank select picks the addressed bank
// - Read mask high floats data two cycles later
// - Write mask high blocks that word now
`timescale 1ns/1ps
`default_nettype none
module sdram_cmd_port #(
   parameter logic [1:0] ORG = sdram_cmd_pkg::ORG_X4,
   parameter logic [3:0] BURST_LEN = sdram_cmd_pkg::BURST_LEN_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic clk_gate,
   input wire logic select_n,
   input wire logic row_n,
   input wire logic col_n,
   input wire logic write_n,
   input wire logic [11:0] addr_bus,
   input wire logic [1:0] bank_sel,
   input wire logic data_mask,
   output logic [3:0] bank_open,
   output logic [11:0] row_addr,
   output logic [11:0] col_addr,
   output logic [1:0] burst_bank,
   output logic burst_busy,
   output logic burst_write,
   output logic write_strobe,
   output logic data_oe,
   output logic low_power,
   output logic self_refresh
);
   ////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [3:0] open;
      logic [11:0] row;
      logic [11:0] col;
      logic [1:0] bank;
      logic [3:0] left;
      logic busy;
      logic wr;
      logic auto_pre;
      logic wstb;
      logic [1:0] mask_pipe;
      logic oe;
      logic gate_q;
      logic lowp;
      logic sref;
   } state_s;

   state_s cur;
   state_s next_cur;

   function automatic logic [11:0] column_of(input logic [11:0] a);
      unique case (ORG)
         sdram_cmd_pkg::ORG_X4: column_of = {a[11], 1'b0, a[9:0]};
         sdram_cmd_pkg::ORG_X8: column_of = {2'h0, a[9:0]};
         default: column_of = {3'h0, a[8:0]};
      endcase
   endfunction

   logic [2:0] cmd;
   logic decode;
   logic ap;
   assign cmd = {row_n, col_n, write_n};
   assign ap = addr_bus[sdram_cmd_pkg::PRECHARGE_BIT];

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      next_cur = cur;
      decode = cur.gate_q && !select_n;
      next_cur.gate_q = clk_gate;
      next_cur.wstb = 1'b0;
      if (cur.gate_q) begin
         next_cur.lowp = 1'b0;
         next_cur.sref = 1'b0;
         // Mask history runs every cycle that gate_q is high so a read sees fresh samples
         next_cur.mask_pipe = {cur.mask_pipe[0], data_mask};
         // Burst progress continues regardless of select
         if (cur.busy) begin
            next_cur.wstb = cur.wr && !data_mask;
            next_cur.oe = !cur.wr && !cur.mask_pipe[1];
            next_cur.left = cur.left - 4'h1;
            next_cur.col = cur.col + 12'h001;
            if (cur.left == 4'h1) begin
               next_cur.busy = 1'b0;
               next_cur.oe = 1'b0;
               if (cur.auto_pre)
                  next_cur.open[cur.bank] = 1'b0;
            end
         end
         if (decode) begin
            unique case (cmd)
               sdram_cmd_pkg::CMD_ACTIVATE: begin
                  next_cur.row = addr_bus;
                  next_cur.open[bank_sel] = 1'b1;
               end
               sdram_cmd_pkg::CMD_PRECHARGE: begin
                  if (ap)
                     next_cur.open = 4'h0;
                  else
                     next_cur.open[bank_sel] = 1'b0;
               end
               sdram_cmd_pkg::CMD_READ, sdram_cmd_pkg::CMD_WRITE: begin
                  if (cur.open[bank_sel]) begin
                     next_cur.col = column_of(addr_bus);
                     next_cur.bank = bank_sel;
                     // Command edge carries the first beat
                     next_cur.busy = BURST_LEN != 4'h1;
                     next_cur.left = BURST_LEN - 4'h1;
                     next_cur.wr = !write_n;
                     next_cur.auto_pre = ap;
                     next_cur.wstb = !write_n && !data_mask;
                     if (BURST_LEN == 4'h1 && ap)
                        next_cur.open[bank_sel] = 1'b0;
                  end
               end
               sdram_cmd_pkg::CMD_STOP: begin
                  next_cur.busy = 1'b0;
                  next_cur.oe = 1'b0;
               end
               sdram_cmd_pkg::CMD_REFRESH: begin
                  if (!clk_gate && cur.open == 4'h0)
                     next_cur.sref = 1'b1;
               end
               default: begin
               end
            endcase
         end
         if (!clk_gate)
            next_cur.lowp = 1'b1;
      end else begin
         // Internal clock stopped; hold state until gate returns
         next_cur.lowp = !clk_gate || cur.lowp;
         if (clk_gate)
            next_cur.sref = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cur <= '0;
         cur.open <= sdram_cmd_pkg::OPEN_RST;
         cur.row <= sdram_cmd_pkg::ADDR_RST;
         cur.col <= sdram_cmd_pkg::ADDR_RST;
      end else begin
         cur <= next_cur;
      end
   end

   assign bank_open = cur.open;
   assign row_addr = cur.row;
   assign col_addr = cur.col;
   assign burst_bank = cur.bank;
   assign burst_busy = cur.busy;
   assign burst_write = cur.wr;
   assign write_strobe = cur.wstb;
   assign data_oe = cur.oe;
   assign low_power = cur.lowp;
   assign self_refresh = cur.sref;

   ////////////////////////////////////////////////////////////////////
   property p_precharge_all;
      @(posedge clk) disable iff (sys_rst)
      (cur.gate_q && !select_n && cmd == sdram_cmd_pkg::CMD_PRECHARGE && ap)
      |=> bank_open == 4'h0;
   endproperty
   a_precharge_all: assert property (p_precharge_all)
      else $error("precharge all left a bank open");

   property p_precharge_one;
      @(posedge clk) disable iff (sys_rst)
      (cur.gate_q && !select_n && cmd == sdram_cmd_pkg::CMD_PRECHARGE && !ap)
      |=> !bank_open[$past(bank_sel)];
   endproperty
   a_precharge_one: assert property (p_precharge_one)
      else $error("single precharge missed the bank");

   property p_activate;
      @(posedge clk) disable iff (sys_rst)
      (cur.gate_q && !select_n && cmd == sdram_cmd_pkg::CMD_ACTIVATE)
      |=> row_addr == $past(addr_bus) && bank_open[$past(bank_sel)];
   endproperty
   a_activate: assert property (p_activate)
      else $error("activate did not capture row");

   property p_deselect;
      @(posedge clk) disable iff (sys_rst)
      (select_n && !cur.busy) |=> $stable(bank_open);
   endproperty
   a_deselect: assert property (p_deselect)
      else $error("deselected command changed banks");

   property p_gate_low;
      @(posedge clk) disable iff (sys_rst)
      (!clk_gate) |=> low_power ##1 $stable(bank_open);
   endproperty
   a_gate_low: assert property (p_gate_low)
      else $error("clock gate low did not halt");

   property p_write_mask;
      @(posedge clk) disable iff (sys_rst)
      (write_strobe) |-> $past(data_mask) == 1'b0 && burst_write;
   endproperty
   a_write_mask: assert property (p_write_mask)
      else $error("masked word was written");

   property p_read_mask;
      @(posedge clk) disable iff (sys_rst)
      (cur.gate_q && data_mask) ##1 cur.gate_q [*2]
      |=> !data_oe;
   endproperty
   a_read_mask: assert property (p_read_mask)
      else $error("read mask did not float data");

   property p_column;
      @(posedge clk) disable iff (sys_rst)
      (cur.gate_q && !select_n && cmd == sdram_cmd_pkg::CMD_READ
       && cur.open[bank_sel])
      |=> col_addr == column_of($past(addr_bus)) && burst_busy;
   endproperty
   a_column: assert property (p_column)
      else $error("column capture wrong");
endmodule // sdram_cmd_port
`default_nettype wire

/* File: rtl/sdram_cmd_pkg.sv */
// Constants for the command and address port of a four-bank SDRAM.
// Assumes one clock; inputs are synchronous to it.
package sdram_cmd_pkg;
   // Command codes on {row_n, col_n, write_n}
   localparam logic [2:0] CMD_ACTIVATE = 3'h3;
   localparam logic [2:0] CMD_PRECHARGE = 3'h2;
   localparam logic [2:0] CMD_WRITE = 3'h4;
   localparam logic [2:0] CMD_READ = 3'h5;
   localparam logic [2:0] CMD_MODE = 3'h0;
   localparam logic [2:0] CMD_REFRESH = 3'h1;
   localparam logic [2:0] CMD_STOP = 3'h6;
   localparam logic [2:0] CMD_NOP = 3'h7;
   // Organizations
   localparam logic [1:0] ORG_X4 = 2'h0;
   localparam logic [1:0] ORG_X8 = 2'h1;
   localparam logic [1:0] ORG_X16 = 2'h2;
   // Address field positions
   localparam int PRECHARGE_BIT = 10;
   localparam int ADDR_W = 12;
   localparam int BANKS = 4;
   // Read mask latency in cycles
   localparam int READ_MASK_LAT = 2;
   // Default burst length
   localparam logic [3:0] BURST_LEN_DEF = 4'h4;
   // Reset values
   localparam logic [3:0] OPEN_RST = 4'h0;
   localparam logic [11:0] ADDR_RST = 12'h000;
endpackage

/* File: tb/sdram_ctrl_model.sv */
// Controller model that drives the command pins of the SDRAM port.
// Assumes clk comes from the bench; pins change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module sdram_ctrl_model (
   input wire logic clk,
   output logic select_n,
   output logic row_n,
   output logic col_n,
   output logic write_n,
   output logic [11:0] addr_bus,
   output logic [1:0] bank_sel
);
   initial begin
      {select_n, row_n, col_n, write_n} = 4'hF;
      addr_bus = 12'h000;
      bank_sel = 2'h0;
   end
   // One command for one cycle, then deselect with a scrambled bus
   task automatic issue(input logic sel, input logic [2:0] cmd,
         input logic [1:0] bank, input logic [11:0] addr);
      @(negedge clk);
      select_n = sel;
      {row_n, col_n, write_n} = cmd;
      bank_sel = bank;
      addr_bus = addr;
      @(negedge clk);
      select_n = 1'b1;
      {row_n, col_n, write_n} = 3'h7;
      addr_bus = ~addr_bus;
      bank_sel = ~bank_sel;
   endtask
endmodule // sdram_ctrl_model
`default_nettype wire

/* File: tb/test_sdram_cmd_port.sv */
// Self-checking bench for the SDRAM command and address port.
// Assumes the x4 organization and a burst of four beats.
`timescale 1ns/1ps
`default_nettype none
module test_sdram_cmd_port;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic clk_gate = 1'b0;
   logic data_mask = 1'b0;
   wire logic select_n, row_n, col_n, write_n;
   wire logic [11:0] addr_bus;
   wire logic [1:0] bank_sel;
   logic [3:0] bank_open;
   logic [11:0] row_addr, col_addr;
   logic burst_busy, write_strobe, data_oe, low_power;
   logic [1:0] burst_bank;
   logic burst_write, self_refresh;
   int err_count = 0;
   int tests_run = 0;
   int cycles = 0;
   int oe_cnt = 0;
   int ws_cnt = 0;
   always #5 clk = ~clk;
   sdram_ctrl_model ctl (.clk(clk), .select_n(select_n), .row_n(row_n),
      .col_n(col_n), .write_n(write_n), .addr_bus(addr_bus),
      .bank_sel(bank_sel));
   sdram_cmd_port #(.ORG(sdram_cmd_pkg::ORG_X4), .BURST_LEN(4'h4)) dut (
      .clk(clk), .sys_rst(sys_rst), .clk_gate(clk_gate),
      .select_n(select_n), .row_n(row_n), .col_n(col_n),
      .write_n(write_n), .addr_bus(addr_bus), .bank_sel(bank_sel),
      .data_mask(data_mask), .bank_open(bank_open), .row_addr(row_addr),
      .col_addr(col_addr), .burst_bank(burst_bank),
      .burst_busy(burst_busy), .burst_write(burst_write),
      .write_strobe(write_strobe), .data_oe(data_oe),
      .low_power(low_power), .self_refresh(self_refresh));
   ////////////////////////////////////////////////////////////////////
   task automatic end_of_test;
      $display("tests_run %0d err_count %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk(input string name, input logic [11:0] exp,
         input logic [11:0] got);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s exp %h got %h", name, exp, got);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   always @(posedge clk) begin
      cycles++;
      oe_cnt += (data_oe === 1'b1);
      ws_cnt += (write_strobe === 1'b1);
      if (cycles == 1000) begin
         err_count++;
         end_of_test();
      end
   end
   ////////////////////////////////////////////////////////////////////
   initial begin
      idle(10);
      sys_rst = 1'b0;
      clk_gate = 1'b1;
      idle(1);
      chk("bank_open", 12'h000, {8'h00, bank_open});
      ctl.issue(1'b0, sdram_cmd_pkg::CMD_ACTIVATE, 2'h1, 12'hABC);
      idle(1);
      chk("bank_open", 12'h002, {8'h00, bank_open});
      chk("row_addr", 12'hABC, row_addr);
      ctl.issue(1'b1, sdram_cmd_pkg::CMD_ACTIVATE, 2'h2, 12'h123);
      idle(1);
      chk("bank_open", 12'h002, {8'h00, bank_open});
      $display("test activate done");
      oe_cnt = 0;
      ctl.issue(1'b0, sdram_cmd_pkg::CMD_READ, 2'h1, 12'h9A5);
      chk("col_addr", 12'h9A5, col_addr);
      chk("burst_busy", 12'h001, {11'h0, burst_busy});
      chk("burst_bank", 12'h001, {10'h0, burst_bank});
      chk("burst_write", 12'h000, {11'h0, burst_write});
      idle(8);
      chk("bank_open", 12'h002, {8'h00, bank_open});
      chk("data_oe", 12'h001, {11'h0, oe_cnt != 0});
      data_mask = 1'b1;
      oe_cnt = 0;
      ws_cnt = 0;
      ctl.issue(1'b0, sdram_cmd_pkg::CMD_READ, 2'h1, 12'h011);
      idle(8);
      chk("data_oe", 12'h000, oe_cnt[11:0]);
      ctl.issue(1'b0, sdram_cmd_pkg::CMD_WRITE, 2'h1, 12'h022);
      idle(8);
      chk("write_strobe", 12'h000, ws_cnt[11:0]);
      data_mask = 1'b0;
      ws_cnt = 0;
      ctl.issue(1'b0, sdram_cmd_pkg::CMD_WRITE, 2'h1, 12'hC05);
      chk("col_addr", 12'h805, col_addr);
      chk("burst_write", 12'h001, {11'h0, burst_write});
      idle(8);
      chk("write_strobe", 12'h004, ws_cnt[11:0]);
      chk("bank_open", 12'h000, {8'h00, bank_open});
      $display("test burst done");
      ctl.issue(1'b0, sdram_cmd_pkg::CMD_ACTIVATE, 2'h0, 12'h001);
      ctl.issue(1'b0, sdram_cmd_pkg::CMD_ACTIVATE, 2'h3, 12'h002);
      ctl.issue(1'b0, sdram_cmd_pkg::CMD_PRECHARGE, 2'h3, 12'h000);
      idle(1);
      chk("bank_open", 12'h001, {8'h00, bank_open});
      ctl.issue(1'b0, sdram_cmd_pkg::CMD_PRECHARGE, 2'h2, 12'h400);
      idle(1);
      chk("bank_open", 12'h000, {8'h00, bank_open});
      $display("test precharge done");
      clk_gate = 1'b0;
      idle(4);
      chk("low_power", 12'h001, {11'h0, low_power});
      clk_gate = 1'b1;
      idle(4);
      chk("low_power", 12'h000, {11'h0, low_power});
      $display("test clock gate done");
      // Refresh taken while the gate drops at the same edge
      fork
         ctl.issue(1'b0, sdram_cmd_pkg::CMD_REFRESH, 2'h0, 12'h000);
         begin
            @(negedge clk);
            clk_gate = 1'b0;
         end
      join
      idle(2);
      chk("self_refresh", 12'h001, {11'h0, self_refresh});
      clk_gate = 1'b1;
      idle(2);
      chk("self_refresh", 12'h000, {11'h0, self_refresh});
      $display("test self refresh done");
      end_of_test();
   end
endmodule // test_sdram_cmd_port
`default_nettype wire
